// ===== bopis_core.v
// byte-op slice: decode and execute of rotate, set, sleep and subtract, AHB-Lite registers
//
// Overview of operation
// - rotate-right opcode decoded; bit 9 destination, bit 8 bank access, low byte address
// - rotate moves bit 0 into bit 7, updates only negative and zero
// - destination bit 0 writes working register, 1 writes back to file register
// - bank access bit 0 uses access bank, 1 uses bank select register
// - access bit 0, extended set on, address up to 5Fh: indexed offset addressing
// - set-register writes FFh, honours bank access bit, leaves flags unchanged
// - sleep opcode stops oscillator, entry completes in fourth quarter
// - sleep clears power-down flag and sets time-out flag
// - sleep clears watchdog counter and its postscaler
// - watchdog time-out waking from sleep clears time-out flag
// - subtract with borrow: working minus file minus inverted carry, five flags
// - subtraction is two's complement, carry one means no borrow
`timescale 1ns/1ps
`include "bopis_regs.vh"

module bopis_core (
   clk,
   reset_n,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hreadyout,
   hresp,
   hrdata,
   sleeping,
   osc_run
);
   input  wire        clk;
   input  wire        reset_n;
   input  wire        hsel;
   input  wire [31:0] haddr;
   input  wire [1:0]  htrans;
   input  wire        hwrite;
   input  wire [2:0]  hsize;
   input  wire [31:0] hwdata;
   input  wire        hready;
   output wire        hreadyout;
   output wire        hresp;
   output reg  [31:0] hrdata;
   output wire        sleeping;
   output wire        osc_run;

   // ****************************************
   // reset release
   // ****************************************
   reg rst_meta_r;
   reg rst_n_r;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ****************************************
   // state and registers
   // ****************************************
   localparam [2:0] Q_IDLE = 3'h0;
   localparam [2:0] Q_DEC  = 3'h1;
   localparam [2:0] Q_READ = 3'h2;
   localparam [2:0] Q_PROC = 3'h3;
   localparam [2:0] Q_WRT  = 3'h4;

   reg  [2:0]  q_r;
   reg  [15:0] ir_r;
   reg  [7:0]  w_r;
   reg  [6:0]  status_r;
   reg  [3:0]  bank_r;
   reg  [1:0]  ctrl_r;
   reg  [8:0]  index_r;
   reg  [8:0]  ramaddr_r;
   reg         sleep_r;
   reg         drop_r;
   reg         illegal_r;
   reg         wake_r;
   reg  [7:0]  post_r;
   reg  [7:0]  wdt_r;
   reg  [2:0]  op_r;
   reg         wr_file_r;
   reg         wr_w_r;
   reg         upd_r;
   reg         is_sleep_r;
   reg  [8:0]  ea_r;
   reg  [7:0]  opnd_r;
   reg  [7:0]  res_r;
   reg  [4:0]  flags_r;

   // ****************************************
   // bus address phase capture
   // ****************************************
   reg        dp_wr_r;
   reg  [7:0] dp_addr_r;
   wire       ap_take;

   assign ap_take   = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         dp_wr_r   <= 1'b0;
         dp_addr_r <= 8'h00;
      end else begin
         dp_wr_r   <= ap_take && hwrite && (haddr[31:8] == 24'h000000);
         dp_addr_r <= haddr[7:0];
      end
   end

   wire sw_wr_instr  = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_INSTR);
   wire sw_wr_w      = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_WREG);
   wire sw_wr_status = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_STATUS);
   wire sw_wr_bank   = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_BANK);
   wire sw_wr_ctrl   = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_CTRL);
   wire sw_wr_index  = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_INDEX);
   wire sw_wr_raddr  = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_RAMADDR);
   wire sw_wr_rdata  = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_RAMDATA);
   wire sw_wr_exec   = dp_wr_r && (dp_addr_r == `BOPIS_ADDR_EXEC);

   // an instruction is only started while idle and awake
   wire start = sw_wr_instr && (q_r == Q_IDLE) && !sleep_r;

   // ****************************************
   // decode and effective address
   // ****************************************
   wire [5:0] opc6    = ir_r[15:10];
   wire [7:0] faddr   = ir_r[7:0];
   wire       dest_f  = ir_r[9];
   wire       acc_bsr = ir_r[8];
   reg  [2:0] dec_op;
   reg        dec_ok;
   reg        dec_dest;
   reg        dec_upd;
   reg  [8:0] ea;

   always @* begin
      dec_op   = `BOPIS_OP_ROR;
      dec_ok   = 1'b1;
      dec_dest = dest_f;
      dec_upd  = 1'b1;
      if (opc6 == `BOPIS_OPC_ROR) begin
         dec_op = `BOPIS_OP_ROR;
      end else if (ir_r[15:9] == `BOPIS_OPC_SET_REGISTER_ALL_ONES) begin
         dec_op   = `BOPIS_OP_SET_REGISTER_ALL_ONES;
         dec_dest = 1'b1;
         dec_upd  = 1'b0;
      end else if (opc6 == `BOPIS_OPC_SUB_REG_FROM_ACC_WITH_BORROW) begin
         dec_op = `BOPIS_OP_SUB_REG_FROM_ACC_WITH_BORROW;
      end else if (ir_r[15:8] == `BOPIS_OPC_SUB_ACC_FROM_LITERAL) begin
         dec_op   = `BOPIS_OP_SUB_ACC_FROM_LITERAL;
         dec_dest = 1'b0;
      end else if (opc6 == `BOPIS_OPC_SUB_ACC_FROM_REG) begin
         dec_op = `BOPIS_OP_SUB_ACC_FROM_REG;
      end else begin
         dec_ok = 1'b0;
      end
      // access-bank addresses from 60h up stand in for the special register area
      if (!acc_bsr && ctrl_r[`BOPIS_CTRL_EXT] && (faddr <= `BOPIS_IDX_LIMIT)) begin
         ea = index_r + {1'b0, faddr};
      end else if (!acc_bsr) begin
         ea = {(faddr >= `BOPIS_ACCESS_SPLIT), faddr};
      end else begin
         ea = {bank_r[0], faddr};
      end
   end

   // ****************************************
   // data path
   // ****************************************
   wire [7:0] ram_q;
   wire [7:0] ram_sw_q;
   wire [7:0] alu_res;
   wire [4:0] alu_flags;
   wire       exec_we = (q_r == Q_WRT) && wr_file_r;

   bopis_ram u_ram (
      .clk     (clk),
      .we      (exec_we || (sw_wr_rdata && (q_r == Q_IDLE))),
      .waddr   (exec_we ? ea_r : ramaddr_r),
      .wdata   (exec_we ? res_r : hwdata[7:0]),
      .raddr_a (ea_r),
      .rdata_a (ram_q),
      .raddr_b (ramaddr_r),
      .rdata_b (ram_sw_q)
   );

   bopis_alu u_alu (
      .op    (op_r),
      .fval  (opnd_r),
      .wval  (w_r),
      .kval  (ir_r[7:0]),
      .c_in  (status_r[`BOPIS_ST_C]),
      .res   (alu_res),
      .flags (alu_flags)
   );

   // ****************************************
   // watchdog
   // ****************************************
   wire wdt_tick = ctrl_r[`BOPIS_CTRL_WDT] && (post_r == `BOPIS_WDT_POST_MAX);
   wire wdt_to   = wdt_tick && (wdt_r == `BOPIS_WDT_CNT_MAX);
   wire sleep_go = (q_r == Q_WRT) && is_sleep_r;

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         post_r <= 8'h00;
         wdt_r  <= 8'h00;
      end else if (sleep_go) begin
         post_r <= 8'h00;
         wdt_r  <= 8'h00;
      end else if (ctrl_r[`BOPIS_CTRL_WDT]) begin
         post_r <= post_r + 8'h01;
         if (wdt_tick) begin
            wdt_r <= wdt_r + 8'h01;
         end
      end
   end

   // ****************************************
   // quarter-cycle sequencer
   // ****************************************
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         q_r        <= Q_IDLE;
         ir_r       <= 16'h0000;
         op_r       <= `BOPIS_OP_ROR;
         wr_file_r  <= 1'b0;
         wr_w_r     <= 1'b0;
         upd_r      <= 1'b0;
         is_sleep_r <= 1'b0;
         ea_r       <= 9'h000;
         opnd_r     <= 8'h00;
         res_r      <= 8'h00;
         flags_r    <= 5'h00;
      end else begin
         case (q_r)
            Q_IDLE: begin
               if (start) begin
                  ir_r <= hwdata[15:0];
                  q_r  <= Q_DEC;
               end
            end
            Q_DEC: begin
               op_r       <= dec_op;
               wr_file_r  <= dec_ok && dec_dest;
               wr_w_r     <= dec_ok && !dec_dest;
               upd_r      <= dec_ok && dec_upd;
               is_sleep_r <= (ir_r == `BOPIS_OPC_SLEEP);
               ea_r       <= ea;
               q_r        <= Q_READ;
            end
            Q_READ: begin
               opnd_r <= ram_q;
               q_r    <= Q_PROC;
            end
            Q_PROC: begin
               res_r   <= alu_res;
               flags_r <= alu_flags;
               q_r     <= Q_WRT;
            end
            default: begin
               wr_file_r  <= 1'b0;
               wr_w_r     <= 1'b0;
               upd_r      <= 1'b0;
               is_sleep_r <= 1'b0;
               q_r        <= Q_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // working register, flags, sleep state
   // ****************************************
   wire dec_bad = (q_r == Q_DEC) && !dec_ok && (ir_r != `BOPIS_OPC_SLEEP);

   // hardware writes take priority over software writes in the same cycle
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         w_r       <= 8'h00;
         status_r  <= `BOPIS_STATUS_RST;
         sleep_r   <= 1'b0;
         drop_r    <= 1'b0;
         illegal_r <= 1'b0;
         wake_r    <= 1'b0;
      end else begin
         if ((q_r == Q_WRT) && wr_w_r) begin
            w_r <= res_r;
         end else if (sw_wr_w) begin
            w_r <= hwdata[7:0];
         end
         if ((q_r == Q_WRT) && upd_r) begin
            status_r[`BOPIS_ST_N] <= flags_r[`BOPIS_ST_N];
            status_r[`BOPIS_ST_Z] <= flags_r[`BOPIS_ST_Z];
            if (op_r != `BOPIS_OP_ROR) begin
               status_r[`BOPIS_ST_C]  <= flags_r[`BOPIS_ST_C];
               status_r[`BOPIS_ST_DC] <= flags_r[`BOPIS_ST_DC];
               status_r[`BOPIS_ST_OV] <= flags_r[`BOPIS_ST_OV];
            end
         end else if (sw_wr_status) begin
            status_r[4:0] <= hwdata[4:0];
         end
         if (sleep_go) begin
            status_r[`BOPIS_ST_PD] <= 1'b0;
            status_r[`BOPIS_ST_TO] <= 1'b1;
            sleep_r                <= 1'b1;
         end else if (wdt_to) begin
            status_r[`BOPIS_ST_TO] <= 1'b0;
            sleep_r                <= 1'b0;
         end
         // sticky events: a set in the clearing cycle wins
         if (sw_wr_instr && !start) begin
            drop_r <= 1'b1;
         end else if (sw_wr_exec && hwdata[`BOPIS_EX_DROP]) begin
            drop_r <= 1'b0;
         end
         if (dec_bad) begin
            illegal_r <= 1'b1;
         end else if (sw_wr_exec && hwdata[`BOPIS_EX_ILLEGAL]) begin
            illegal_r <= 1'b0;
         end
         if (wdt_to && sleep_r) begin
            wake_r <= 1'b1;
         end else if (sw_wr_exec && hwdata[`BOPIS_EX_WAKE]) begin
            wake_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // software-side control registers
   // ****************************************
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bank_r    <= 4'h0;
         ctrl_r    <= 2'h0;
         index_r   <= 9'h000;
         ramaddr_r <= 9'h000;
      end else begin
         if (sw_wr_bank) begin
            bank_r <= hwdata[3:0];
         end
         if (sw_wr_ctrl) begin
            ctrl_r <= hwdata[1:0];
         end
         if (sw_wr_index) begin
            index_r <= hwdata[8:0];
         end
         if (sw_wr_raddr) begin
            ramaddr_r <= hwdata[8:0];
         end
      end
   end

   // ****************************************
   // read data, latched in the address phase
   // ****************************************
   reg [31:0] rd_mux;
   wire [4:0] exec_bits = {wake_r, illegal_r, drop_r, sleep_r, (q_r != Q_IDLE)};

   always @* begin
      rd_mux = 32'h00000000;
      if (haddr[7:0] == `BOPIS_ADDR_INSTR) begin
         rd_mux = {16'h0000, ir_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_WREG) begin
         rd_mux = {24'h000000, w_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_STATUS) begin
         rd_mux = {25'h0, status_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_BANK) begin
         rd_mux = {28'h0000000, bank_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_CTRL) begin
         rd_mux = {30'h0, ctrl_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_INDEX) begin
         rd_mux = {23'h0, index_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_RAMADDR) begin
         rd_mux = {23'h0, ramaddr_r};
      end else if (haddr[7:0] == `BOPIS_ADDR_RAMDATA) begin
         rd_mux = {24'h000000, ram_sw_q};
      end else if (haddr[7:0] == `BOPIS_ADDR_EXEC) begin
         rd_mux = {27'h0, exec_bits};
      end else if (haddr[7:0] == `BOPIS_ADDR_WATCH) begin
         rd_mux = {16'h0000, wdt_r, post_r};
      end
      if (haddr[31:8] != 24'h000000) begin
         rd_mux = 32'h00000000;
      end
   end

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         hrdata <= 32'h00000000;
      end else if (ap_take && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // oscillator gating is only reported; the bus clock keeps running
   assign sleeping = sleep_r;
   assign osc_run  = !sleep_r;

endmodule

// ===== bopis_regs.vh
// register map, field positions, reset values and timing counts of the byte-op slice
`ifndef BOPIS_REGS_VH
`define BOPIS_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define BOPIS_ADDR_INSTR    8'h00
`define BOPIS_ADDR_WREG     8'h04
`define BOPIS_ADDR_STATUS   8'h08
`define BOPIS_ADDR_BANK     8'h0c
`define BOPIS_ADDR_CTRL     8'h10
`define BOPIS_ADDR_INDEX    8'h14
`define BOPIS_ADDR_RAMADDR  8'h18
`define BOPIS_ADDR_RAMDATA  8'h1c
`define BOPIS_ADDR_EXEC     8'h20
`define BOPIS_ADDR_WATCH    8'h24

// ****************************************
// status fields
// ****************************************
`define BOPIS_ST_C          0
`define BOPIS_ST_DC         1
`define BOPIS_ST_Z          2
`define BOPIS_ST_OV         3
`define BOPIS_ST_N          4
`define BOPIS_ST_PD         5
`define BOPIS_ST_TO         6
`define BOPIS_STATUS_RST    7'h60

// ****************************************
// control and exec fields
// ****************************************
`define BOPIS_CTRL_EXT      0
`define BOPIS_CTRL_WDT      1
`define BOPIS_EX_BUSY       0
`define BOPIS_EX_SLEEP      1
`define BOPIS_EX_DROP       2
`define BOPIS_EX_ILLEGAL    3
`define BOPIS_EX_WAKE       4

// ****************************************
// operations, opcodes and addressing
// ****************************************
`define BOPIS_OP_ROR        3'h0
`define BOPIS_OP_SET_REGISTER_ALL_ONES       3'h1
`define BOPIS_OP_SUB_REG_FROM_ACC_WITH_BORROW     3'h2
`define BOPIS_OP_SUB_ACC_FROM_LITERAL      3'h3
`define BOPIS_OP_SUB_ACC_FROM_REG      3'h4
`define BOPIS_OPC_ROR       6'h10
`define BOPIS_OPC_SET_REGISTER_ALL_ONES      7'h34
`define BOPIS_OPC_SUB_REG_FROM_ACC_WITH_BORROW    6'h15
`define BOPIS_OPC_SUB_ACC_FROM_LITERAL     8'h08
`define BOPIS_OPC_SUB_ACC_FROM_REG     6'h17
`define BOPIS_OPC_SLEEP     16'h0003
`define BOPIS_IDX_LIMIT     8'h5f
`define BOPIS_ACCESS_SPLIT  8'h60

// ****************************************
// watchdog counts
// ****************************************
`define BOPIS_WDT_POST_MAX  8'hff
`define BOPIS_WDT_CNT_MAX   8'hff

`endif

// ===== bopis_alu.v
// byte-op slice data path: rotate, set, and three subtractions with flag outputs
`timescale 1ns/1ps
`include "bopis_regs.vh"

module bopis_alu (
   op,
   fval,
   wval,
   kval,
   c_in,
   res,
   flags
);
   input  wire [2:0] op;
   input  wire [7:0] fval;
   input  wire [7:0] wval;
   input  wire [7:0] kval;
   input  wire       c_in;
   output reg  [7:0] res;
   output reg  [4:0] flags;

   reg  [7:0] x;
   reg  [7:0] y;
   reg        cin;
   reg  [8:0] sum;
   reg  [4:0] low;

   // subtraction as x + ~y + cin: a carry of one means no borrow
   always @* begin
      x   = wval;
      y   = fval;
      cin = c_in;
      if (op == `BOPIS_OP_SUB_ACC_FROM_LITERAL) begin
         x   = kval;
         y   = wval;
         cin = 1'b1;
      end else if (op == `BOPIS_OP_SUB_ACC_FROM_REG) begin
         x   = fval;
         y   = wval;
         cin = 1'b1;
      end
      sum   = {1'b0, x} + {1'b0, ~y} + {8'h00, cin};
      low   = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, cin};
      res   = sum[7:0];
      flags[`BOPIS_ST_C]  = sum[8];
      flags[`BOPIS_ST_DC] = low[4];
      flags[`BOPIS_ST_OV] = (x[7] != y[7]) && (sum[7] != x[7]);
      if (op == `BOPIS_OP_ROR) begin
         res = {fval[0], fval[7:1]};
      end else if (op == `BOPIS_OP_SET_REGISTER_ALL_ONES) begin
         res = 8'hff;
      end
      flags[`BOPIS_ST_Z]  = (res == 8'h00);
      flags[`BOPIS_ST_N]  = res[7];
   end

endmodule

// ===== bopis_ram.v
// byte-op slice file registers: 512 bytes of flip-flops, one write and two read ports
`timescale 1ns/1ps

module bopis_ram (
   clk,
   we,
   waddr,
   wdata,
   raddr_a,
   rdata_a,
   raddr_b,
   rdata_b
);
   input  wire       clk;
   input  wire       we;
   input  wire [8:0] waddr;
   input  wire [7:0] wdata;
   input  wire [8:0] raddr_a;
   output wire [7:0] rdata_a;
   input  wire [8:0] raddr_b;
   output wire [7:0] rdata_b;

   reg [7:0] mem [0:511];

   // contents are not reset, like real data memory
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];

endmodule

// ===== bopis_core_chk.sv
// port checker of the byte-op slice, bound to the core
`timescale 1ns/1ps
module bopis_core_chk (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        sleeping,
   input wire logic        osc_run
);
   // ****************************************
   // data-phase trackers
   // ****************************************
   logic tk;
   logic rd_r;
   logic unm_r;
   logic st_r;
   logic wi_r;
   assign tk = hsel && htrans[1] && hready;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_r <= 1'b0;
         unm_r <= 1'b0;
         st_r <= 1'b0;
         wi_r <= 1'b0;
      end else begin
         rd_r <= tk && !hwrite;
         unm_r <= haddr[31:8] != 24'h0;
         st_r <= haddr == 32'h8;
         wi_r <= tk && hwrite && haddr == 32'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_READY: assert property (hreadyout) else $error("wait state inserted");
   AST_RESP: assert property (!hresp) else $error("error response");
   AST_OSC: assert property (osc_run == !sleeping) else $error("oscillator run wrong");
   // sleep only ever follows an opcode written five sampled edges before
   AST_SLEEP_ENTRY: assert property ($rose(sleeping) |->
      $past(wi_r && hwdata[15:0] == 16'h0003, 5)) else $error("sleep without opcode");
   // watchdog restarts from zero, so no wake can come soon after entry
   AST_SLEEP_HOLD: assert property ($rose(sleeping) |-> sleeping[*8])
      else $error("early wake");
   AST_RD_STABLE: assert property (!rd_r |-> $stable(hrdata)) else $error("read data moved");
   AST_UNMAPPED: assert property (rd_r && unm_r |-> hrdata == 32'h0) else $error("unmapped data");
   AST_SLEEP_STATUS: assert property (rd_r && st_r && $past(sleeping) |->
      hrdata[6:5] == 2'b10) else $error("sleep status flags");
   AST_STATUS_HI: assert property (rd_r && st_r |-> hrdata[31:7] == 25'h0)
      else $error("status upper bits");
   cover property ($rose(sleeping));
   cover property ($fell(sleeping));
   cover property (rd_r && unm_r);
endmodule

bind bopis_core bopis_core_chk u_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .sleeping(sleeping), .osc_run(osc_run));

// ===== byte_op_instruction_slice_tb.sv
// self-checking testbench of the byte-op slice
`timescale 1ns/1ps
`include "bopis_regs.vh"
module byte_op_instruction_slice_tb;
   logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, q;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   wire         hrdy, hresp, sleeping, osc_run;
   wire  [31:0] hrdata;
   int          failures = 0, n_checks = 0, cyc = 0, i, k;
   logic [2:0]  op;
   logic        d, ws;
   logic [7:0]  f, fv, wv;
   logic [4:0]  st;
   logic [12:0] e;
   logic [15:0] ir;
   bopis_core DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
      .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .sleeping(sleeping),
      .osc_run(osc_run));
   initial begin
      forever #25 clk = ~clk;
   end
   // ****************************************
   // bus, check and model helpers
   // ****************************************
   task finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         failures++;
         finish_test;
      end
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] dd,
            output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= dd;
      do @(posedge clk); while (hrdy !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] dd);
      logic [31:0] r;
      bus(1'b1, a, dd, r);
   endtask
   task rd(input logic [31:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   task exec(input logic [15:0] x);
      logic [31:0] r;
      int n;
      wr(`BOPIS_ADDR_INSTR, {16'h0, x});
      r = 32'h1;
      for (n = 0; n < 20 && r[0] !== 1'b0; n++) rd(`BOPIS_ADDR_EXEC, r);
      chk("busy", {31'h0, r[0]}, 32'h0);
   endtask
   // set_register_all_ones at one address form, then look where the byte must have landed
   task place(input logic [15:0] x, input logic [8:0] ra);
      logic [31:0] r;
      wr(`BOPIS_ADDR_RAMADDR, {23'h0, ra});
      wr(`BOPIS_ADDR_RAMDATA, 32'h0);
      exec(x);
      rd(`BOPIS_ADDR_RAMDATA, r);
      chk("placed", r, 32'hff);
   endtask
   function automatic logic [12:0] model(input logic [2:0] o, input logic [7:0] fa,
                                         input logic [7:0] wa, input logic [4:0] s);
      logic [8:0] t;
      logic [4:0] h, y;
      logic [7:0] a, b;
      logic ci;
      a = (o == 3'h2) ? wa : fa;
      b = (o == 3'h2) ? fa : wa;
      ci = (o == 3'h2) ? s[0] : 1'b1;
      t = {1'b0, a} + {1'b0, ~b} + {8'h0, ci};
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
      y = s;
      if (o == 3'h0) begin
         t = {1'b0, fa[0], fa[7:1]};
         y[4] = t[7];
         y[2] = t[7:0] == 8'h0;
      end else if (o == 3'h1) t = 9'hff;
      else y = {t[7], (a[7] != b[7]) && (t[7] != a[7]), t[7:0] == 8'h0, h[4], t[8]};
      return {y, t[7:0]};
   endfunction
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      k = $urandom(32'hbae57be0);
      rd(`BOPIS_ADDR_STATUS, q);
      chk("status reset", q, 32'h60);
      rd(32'h100, q);
      chk("unmapped", q, 32'h0);
      wr(`BOPIS_ADDR_CTRL, 32'h2);
      for (i = 0; i < 60; i++) begin
         op = (i < 5) ? i[2:0] : 3'($urandom_range(4, 0));
         d = $urandom;
         f = $urandom_range(95, 0);
         fv = (i == 2) ? 8'h80 : $urandom;
         wv = (i == 4) ? 8'h80 : $urandom;
         st = $urandom;
         case (op)
            3'h0: ir = {`BOPIS_OPC_ROR, d, 1'b0, f};
            3'h1: ir = {`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, f};
            3'h2: ir = {`BOPIS_OPC_SUB_REG_FROM_ACC_WITH_BORROW, d, 1'b0, f};
            3'h3: ir = {`BOPIS_OPC_SUB_ACC_FROM_LITERAL, fv};
            default: ir = {`BOPIS_OPC_SUB_ACC_FROM_REG, d, 1'b0, f};
         endcase
         wr(`BOPIS_ADDR_RAMADDR, {24'h0, f});
         wr(`BOPIS_ADDR_RAMDATA, {24'h0, fv});
         wr(`BOPIS_ADDR_WREG, {24'h0, wv});
         wr(`BOPIS_ADDR_STATUS, {27'h0, st});
         exec(ir);
         e = model(op, fv, wv, st);
         ws = op == 3'h3 || (!d && op != 3'h1);
         rd(`BOPIS_ADDR_WREG, q);
         chk("w", q, {24'h0, ws ? e[7:0] : wv});
         rd(`BOPIS_ADDR_STATUS, q);
         chk("status", q, {25'h3, e[12:8]});
         rd(`BOPIS_ADDR_RAMDATA, q);
         chk("file", q, {24'h0, ws ? fv : e[7:0]});
      end
      wr(`BOPIS_ADDR_BANK, 32'h1);
      place({`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b1, 8'h22}, 9'h122);
      place({`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, 8'h23}, 9'h023);
      wr(`BOPIS_ADDR_CTRL, 32'h3);
      wr(`BOPIS_ADDR_INDEX, 32'h40);
      place({`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, 8'h10}, 9'h050);
      place({`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, 8'h5f}, 9'h09f);
      place({`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, 8'h60}, 9'h160);
      // unknown opcode runs as a nop but leaves a sticky mark, cleared by writing one
      exec(16'hffff);
      rd(`BOPIS_ADDR_EXEC, q);
      chk("illegal", {31'h0, q[3]}, 32'h1);
      wr(`BOPIS_ADDR_EXEC, 32'h8);
      rd(`BOPIS_ADDR_EXEC, q);
      chk("illegal clear", {31'h0, q[3]}, 32'h0);
      // second instruction word lands while the first is still busy
      wr(`BOPIS_ADDR_INSTR, {16'h0, `BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, 8'h23});
      exec({`BOPIS_OPC_SET_REGISTER_ALL_ONES, 1'b0, 8'h23});
      rd(`BOPIS_ADDR_EXEC, q);
      chk("drop", {31'h0, q[2]}, 32'h1);
      wr(`BOPIS_ADDR_CTRL, 32'h2);
      exec(`BOPIS_OPC_SLEEP);
      chk("sleeping", {30'h0, sleeping, osc_run}, 32'h2);
      rd(`BOPIS_ADDR_STATUS, q);
      chk("sleep flags", {30'h0, q[6:5]}, 32'h2);
      rd(`BOPIS_ADDR_WATCH, q);
      chk("watchdog", {31'h0, q[15:8] == 8'h0 && q[7:0] < 8'h20}, 32'h1);
      // a cleared watchdog needs close to the full period to wake
      for (k = 0; k < 70000 && sleeping !== 1'b0; k++) @(posedge clk);
      chk("wake time", {31'h0, k > 65000 && k < 66000}, 32'h1);
      rd(`BOPIS_ADDR_STATUS, q);
      chk("timeout flag", {31'h0, q[6]}, 32'h0);
      rd(`BOPIS_ADDR_EXEC, q);
      chk("wake event", {31'h0, q[4]}, 32'h1);
      finish_test;
   end
endmodule
